// *** reference_input_config.sv ***
// Reference input configuration bits of the clock generator register map.
// Assumes the serial control port decoder delivers byte accesses on clk_sys,
// and that the status candidates come from logic on the same clock.
// Reset is asynchronous and active high; a write shows on the outputs one edge later.
//
// What this block does
// - Input two powered only when its bit set
// - Input one powered only when its bit set
// - Mode bit picks differential, else single-ended
// - Override set routes store status to pin
// - Override clear routes selected status source
// - Crystal bit enables the maintaining amplifier
`timescale 1ns/10ps
`default_nettype none
`include "ref_cfg_map.svh"

module reference_input_config
  import ref_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,

  // Register access from the serial control port
  input wire logic [`REG_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [`REG_DATA_W-1:0] regWrData,
  input wire logic regRdEn,
  output logic [`REG_DATA_W-1:0] regRdData,
  output logic regRdValid,

  // Status pin source
  input wire logic [`STATUS_SEL_W-1:0] statusSelect,
  input wire logic [`STATUS_SRC_COUNT-1:0] statusSources,
  input wire logic storeTransferStatus,
  output logic statusOut,

  // Reference input front end
  output logic referenceInputOnePowerEn,
  output logic referenceInputTwoPowerEn,
  output logic differentialMode,
  output logic crystalAmplifierEn,

  // Neighbouring controls held in the same registers
  output logic switchoverDeglitchOff,
  output logic selectInputTwo,
  output logic useSelectPin,
  output logic doublerEn,
  output logic pllStatusOff,
  output logic lockComparatorEn,
  output logic externalHoldoverEn,
  output logic holdoverEn
);

  cfg_state_t st;
  cfg_state_t next_st;

  // Reset image of the whole state; constants only
  localparam cfg_state_t RESET_STATE = '{
    refInputControl: `REF_INPUT_CONTROL_RESET,
    refOptionsControl: `REF_OPTIONS_CONTROL_RESET,
    rdData: `UNMAPPED_READ_VALUE,
    rdValid: 1'b0,
    statusOut: 1'b0
  };

  // Decoded access strobes
  reg_sel_t wrSel;
  reg_sel_t rdSel;
  logic wrInputControl;
  logic wrOptionsControl;

  // Status pin inputs after the override choice
  logic storeOverride;
  logic nextStatus;

  // Decode shared by the write and read paths
  function automatic reg_sel_t decodeAddr(input logic [`REG_ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == `REF_INPUT_CONTROL_OFFSET) begin
      sel = SEL_INPUT_CONTROL;
    end else if (addr == `REF_OPTIONS_CONTROL_OFFSET) begin
      sel = SEL_OPTIONS_CONTROL;
    end
    return sel;
  endfunction : decodeAddr

  // Byte update shared by both registers; every bit is plain storage
  function automatic reg_byte_t updateByte(
    input reg_byte_t old,
    input logic hit,
    input reg_byte_t data
  );
    reg_byte_t upd;
    upd = old;
    if (hit) begin
      upd = data;
    end
    return upd;
  endfunction : updateByte

  // Readback byte of one register; unmapped space reads as a constant
  function automatic reg_byte_t readBack(
    input reg_sel_t sel,
    input reg_byte_t inputControl,
    input reg_byte_t optionsControl
  );
    reg_byte_t data;
    data = `UNMAPPED_READ_VALUE;
    unique case (sel)
      SEL_INPUT_CONTROL: begin
        data = inputControl;
      end
      SEL_OPTIONS_CONTROL: begin
        data = optionsControl;
      end
      SEL_NONE: begin
        data = `UNMAPPED_READ_VALUE;
      end
    endcase
    return data;
  endfunction : readBack

  // Status pin choice; the override masks the selector entirely
  function automatic logic pickStatus(
    input logic override,
    input logic storeStatus,
    input logic [`STATUS_SEL_W-1:0] sel,
    input logic [`STATUS_SRC_COUNT-1:0] sources
  );
    logic pick;
    pick = sources[sel];
    if (override) begin
      pick = storeStatus;
    end
    return pick;
  endfunction : pickStatus

  // One decoder per strobe keeps each path's fan-in visible on its own
  assign wrSel = decodeAddr(regAddr);
  assign rdSel = decodeAddr(regAddr);
  assign wrInputControl = regWrEn && (wrSel == SEL_INPUT_CONTROL);
  assign wrOptionsControl = regWrEn && (wrSel == SEL_OPTIONS_CONTROL);

  // Override bit comes from the stored byte, never from the bus data
  assign storeOverride = st.refOptionsControl[`STATUS_OVERRIDE_BIT];
  assign nextStatus = pickStatus(
    storeOverride,
    storeTransferStatus,
    statusSelect,
    statusSources
  );

  always_comb begin
    next_st = st;

    // Register writes; unmapped writes leave both bytes alone
    next_st.refInputControl = updateByte(
      st.refInputControl,
      wrInputControl,
      regWrData
    );
    next_st.refOptionsControl = updateByte(
      st.refOptionsControl,
      wrOptionsControl,
      regWrData
    );

    // Read answers one cycle after the request from the old contents,
    // so a read that meets a write to the same byte returns the old value
    next_st.rdValid = regRdEn;
    if (regRdEn) begin
      next_st.rdData = readBack(
        rdSel,
        st.refInputControl,
        st.refOptionsControl
      );
    end

    // Pin source registered, one cycle behind its inputs;
    // the flip-flop keeps selector glitches off the pin
    next_st.statusOut = nextStatus;
  end

  // Reset loads constants only, so the front end powers down at once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // Register readback and status pin
  assign regRdData = st.rdData;
  assign regRdValid = st.rdValid;
  assign statusOut = st.statusOut;

  // Front end controls drive straight from the stored bits.
  // No gating in differential mode: software keeps the power bits clear,
  // and gating here would hide a misprogrammed register from readback.
  assign referenceInputTwoPowerEn = st.refInputControl[`REF_INPUT_TWO_EN_BIT];
  assign referenceInputOnePowerEn = st.refInputControl[`REF_INPUT_ONE_EN_BIT];
  assign differentialMode = st.refInputControl[`DIFF_MODE_BIT];
  assign crystalAmplifierEn = st.refOptionsControl[`CRYSTAL_AMPLIFIER_BIT];

  // Reserved bits are stored for readback only and steer nothing

  // Reference selection and deglitch, used by the switchover logic
  assign switchoverDeglitchOff = st.refInputControl[`SWITCHOVER_DEGLITCH_OFF_BIT];
  assign selectInputTwo = st.refInputControl[`SELECT_INPUT_TWO_BIT];
  assign useSelectPin = st.refInputControl[`USE_SELECT_PIN_BIT];

  // Doubler, lock detect and holdover controls
  assign doublerEn = st.refOptionsControl[`DOUBLER_EN_BIT];
  assign pllStatusOff = st.refOptionsControl[`PLL_STATUS_OFF_BIT];
  assign lockComparatorEn = st.refOptionsControl[`LD_COMPARATOR_EN_BIT];
  assign externalHoldoverEn = st.refOptionsControl[`EXT_HOLDOVER_BIT];
  assign holdoverEn = st.refOptionsControl[`HOLDOVER_EN_BIT];

endmodule : reference_input_config
`default_nettype wire

// *** ref_cfg_map.svh ***
// Offsets, field positions and reset values of the reference configuration bits.
// Assumes a byte-wide register space with a 10-bit address.
`ifndef REF_CFG_MAP_SVH
`define REF_CFG_MAP_SVH

// Register space
`define REG_ADDR_W 10
`define REG_DATA_W 8
`define REF_INPUT_CONTROL_OFFSET 10'h01C
`define REF_OPTIONS_CONTROL_OFFSET 10'h01D

// Reference input control fields
`define SWITCHOVER_DEGLITCH_OFF_BIT 7
`define SELECT_INPUT_TWO_BIT 6
`define USE_SELECT_PIN_BIT 5
`define REF_RESERVED_HI_BIT 4
`define REF_RESERVED_LO_BIT 3
`define REF_INPUT_TWO_EN_BIT 2
`define REF_INPUT_ONE_EN_BIT 1
`define DIFF_MODE_BIT 0
`define REF_INPUT_CONTROL_RESET 8'h00

// Reference options control fields
`define STATUS_OVERRIDE_BIT 7
`define CRYSTAL_AMPLIFIER_BIT 6
`define DOUBLER_EN_BIT 5
`define PLL_STATUS_OFF_BIT 4
`define LD_COMPARATOR_EN_BIT 3
`define EXT_HOLDOVER_BIT 1
`define HOLDOVER_EN_BIT 0
`define REF_OPTIONS_CONTROL_RESET 8'h80

// Status selector
`define STATUS_SEL_W 6
`define STATUS_SRC_COUNT 64
`define UNMAPPED_READ_VALUE 8'h00

`endif

// *** ref_cfg_pkg.sv ***
// Types of the reference configuration register bank.
// Assumes ref_cfg_map.svh is on the include path.
`include "ref_cfg_map.svh"

package ref_cfg_pkg;

  typedef logic [`REG_ADDR_W-1:0] reg_addr_t;
  typedef logic [`REG_DATA_W-1:0] reg_byte_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_INPUT_CONTROL,
    SEL_OPTIONS_CONTROL
  } reg_sel_t;

  typedef struct packed {
    reg_byte_t refInputControl;
    reg_byte_t refOptionsControl;
    reg_byte_t rdData;
    logic rdValid;
    logic statusOut;
  } cfg_state_t;

endpackage : ref_cfg_pkg

// *** reference_input_config_chk.sv ***
// Checker of the reference configuration bits.
// Bound into reference_input_config; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module reference_input_config_chk (
  // Clock, reset, bus
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [9:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic regRdValid,
  // Status and front end
  input wire logic [5:0] statusSelect,
  input wire logic [63:0] statusSources,
  input wire logic storeTransferStatus,
  input wire logic statusOut,
  input wire logic referenceInputOnePowerEn,
  input wire logic referenceInputTwoPowerEn,
  input wire logic differentialMode,
  input wire logic crystalAmplifierEn
);
  wire wr1 = regWrEn && regAddr == 10'h01C;
  wire wr2 = regWrEn && regAddr == 10'h01D;
  logic ovr;
  // Own copy of the override bit, so the status path is judged independently
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) ovr <= 1'b1;
    else if (wr2) ovr <= regWrData[7];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  two_pwr_a: assert property (wr1 |=> referenceInputTwoPowerEn == $past(regWrData[2])) else $error("power two");
  one_pwr_a: assert property (wr1 |=> referenceInputOnePowerEn == $past(regWrData[1])) else $error("power one");
  diff_mode_a: assert property (wr1 |=> differentialMode == $past(regWrData[0])) else $error("mode bit");
  store_src_a: assert property (ovr |=> statusOut == $past(storeTransferStatus)) else $error("store status");
  sel_src_a: assert property (!ovr |=> statusOut == $past(statusSources[statusSelect])) else $error("selected");
  xtal_amp_a: assert property (wr2 |=> crystalAmplifierEn == $past(regWrData[6])) else $error("crystal");
  rd_answer_a: assert property (regRdEn |=> regRdValid) else $error("read answer");
  rd_pulse_a: assert property (!regRdEn |=> !regRdValid) else $error("read pulse");
  rsvd_quiet_a: assert property (wr1 && regWrData[2:0] == 3'h0 |=> !referenceInputOnePowerEn
    && !referenceInputTwoPowerEn && !differentialMode) else $error("reserved");
  cover property (wr1 && regWrData[0]);
  cover property (!ovr ##1 statusOut);
  cover property (wr2 && regWrData[6]);
endmodule : reference_input_config_chk
bind reference_input_config reference_input_config_chk i_chk (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
  .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdValid(regRdValid),
  .statusSelect(statusSelect), .statusSources(statusSources),
  .storeTransferStatus(storeTransferStatus), .statusOut(statusOut), .referenceInputOnePowerEn(referenceInputOnePowerEn),
  .referenceInputTwoPowerEn(referenceInputTwoPowerEn), .differentialMode(differentialMode),
  .crystalAmplifierEn(crystalAmplifierEn));
`default_nettype wire

// *** test_reference_input_config.sv ***
// Self-checking bench of the reference configuration bits.
// Drives every port itself; no partner model.
`timescale 1ns/10ps
`default_nettype none
module test_reference_input_config;
  logic clk_sys = 0, rst = 1, regWrEn = 0, regRdEn = 0, store = 0;
  logic [9:0] regAddr = 0;
  logic [7:0] regWrData = 0, regRdData;
  logic [5:0] sel = 0;
  logic [63:0] src = 0;
  logic regRdValid, statusOut, one, two, diff, xtal;
  wire [2:0] selCtl;
  wire [4:0] optCtl;
  int err_total = 0, total_checks = 0;
  always #20 clk_sys = ~clk_sys;
  reference_input_config i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .statusSelect(sel), .statusSources(src), .storeTransferStatus(store), .statusOut(statusOut),
    .referenceInputOnePowerEn(one), .referenceInputTwoPowerEn(two), .differentialMode(diff),
    .crystalAmplifierEn(xtal), .switchoverDeglitchOff(selCtl[2]), .selectInputTwo(selCtl[1]),
    .useSelectPin(selCtl[0]), .doublerEn(optCtl[4]), .pllStatusOff(optCtl[3]), .lockComparatorEn(optCtl[2]),
    .externalHoldoverEn(optCtl[1]), .holdoverEn(optCtl[0]));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [7:0] fe);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    #1;
    chk({4'h0, xtal, two, one, diff}, fe);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk({7'h00, regRdValid}, 8'h01);
    chk(regRdData, exp);
    // Answer strobe lasts one cycle, data holds until the next read
    @(posedge clk_sys);
    #1;
    chk({7'h00, regRdValid}, 8'h00);
    chk(regRdData, exp);
  endtask : rd
  // One sample in, one cycle of lag out
  task automatic st(input logic [5:0] s, input logic [63:0] v, input logic e, input logic exp);
    @(posedge clk_sys);
    sel <= s;
    src <= v;
    store <= e;
    @(posedge clk_sys);
    #1;
    chk({7'h00, statusOut}, {7'h00, exp});
  endtask : st
  task automatic t_reset();
    chk({4'h0, xtal, two, one, diff}, 8'h00);
    rd(10'h01C, 8'h00);
    rd(10'h01D, 8'h80);
    st(6'h00, 64'h0, 1'b1, 1'b1);
  endtask : t_reset
  task automatic t_ref();
    wr(10'h01C, 8'h06, 8'h06);
    wr(10'h01C, 8'h04, 8'h04);
    wr(10'h01C, 8'h01, 8'h01);
    wr(10'h01C, 8'h18, 8'h00);
    rd(10'h01C, 8'h18);
    rd(10'h3FF, 8'h00);
  endtask : t_ref
  task automatic t_stat();
    st(6'h05, 64'h20, 1'b0, 1'b0);
    wr(10'h01D, 8'h40, 8'h08);
    rd(10'h01D, 8'h40);
    st(6'h05, 64'h20, 1'b1, 1'b1);
    st(6'h05, ~64'h20, 1'b1, 1'b0);
    st(6'h3F, 64'h8000_0000_0000_0000, 1'b0, 1'b1);
    wr(10'h01D, 8'h80, 8'h00);
    st(6'h3F, ~64'h0, 1'b0, 1'b0);
  endtask : t_stat
  // Neighbouring controls pass straight from the stored bits
  task automatic t_nbr();
    wr(10'h01C, 8'hE0, 8'h00);
    chk({5'h00, selCtl}, 8'h07);
    wr(10'h01D, 8'hBB, 8'h00);
    chk({3'h0, optCtl}, 8'h1F);
    rd(10'h01D, 8'hBB);
    wr(10'h01D, 8'h80, 8'h00);
    chk({3'h0, optCtl}, 8'h00);
    wr(10'h01C, 8'h00, 8'h00);
    chk({5'h00, selCtl}, 8'h00);
  endtask : t_nbr
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_ref();
    t_stat();
    t_nbr();
    summarize();
  end
  // Tests need under 200 cycles; 2500 is ample
  initial begin
    #100000;
    err_total++;
    summarize();
  end
endmodule : test_reference_input_config
`default_nettype wire
